// *** verilog/egdc_defs.vh ***
`ifndef EGDC_DEFS_VH
`define EGDC_DEFS_VH
// ****************************************
// register byte offsets
// ****************************************
`define EGDC_OFS_CTRL 6'h00
`define EGDC_OFS_ENC_LINES 6'h04
`define EGDC_OFS_PPR 6'h08
`define EGDC_OFS_NUM 6'h0c
`define EGDC_OFS_DEN1 6'h10
`define EGDC_OFS_DEN2 6'h14
`define EGDC_OFS_DEN3 6'h18
`define EGDC_OFS_DEN4 6'h1c
`define EGDC_OFS_STATUS 6'h20
`define EGDC_OFS_MASK 6'h24
`define EGDC_OFS_LIVE 6'h28
`define EGDC_OFS_DEV_LO 6'h2c
`define EGDC_OFS_DEV_HI 6'h30
// ****************************************
// control field positions
// ****************************************
`define EGDC_CTRL_METHOD_LSB 0
`define EGDC_CTRL_SWCOND_BIT 2
`define EGDC_CTRL_FORM_BIT 3
`define EGDC_CTRL_ENCINC_BIT 4
`define EGDC_CTRL_BITS_LSB 5
`define EGDC_CTRL_ASG_LOW_BIT 10
`define EGDC_CTRL_ASG_HIGH_BIT 11
// ****************************************
// status bits
// ****************************************
`define EGDC_ST_CLEARED 0
`define EGDC_ST_FAULT 1
`define EGDC_ST_SWITCHED 2
// ****************************************
// reset values and limits
// ****************************************
`define EGDC_RST_CTRL 12'h220
`define EGDC_RST_ENC_LINES 16'h09c4
`define EGDC_RST_PPR 24'h200000
`define EGDC_MAX_PPR 24'h800000
`define EGDC_RST_NUM 31'h00800000
`define EGDC_RST_DEN 31'h00002710
`define EGDC_MAX_GEAR 31'h40000000
`define EGDC_RATIO_LO_MUL 1000
`define EGDC_RATIO_HI_MUL 30000
`define EGDC_MAX_ENC_BITS 5'd30
// ****************************************
// timing
// ****************************************
`define EGDC_CLK_MHZ 100
`define EGDC_SWITCH_QUIET_MS 3
`endif

// *** verilog/egdc_core.v ***
`timescale 1ns/1ps
`include "egdc_defs.vh"

// Behaviour
// - clear input rising edge clears deviation
// - method 1: clear when disabled or faulted
// - method 2: clear when disabled or input valid
// - nonzero pulses per rev overrides four sets
// - pulses per rev 0..8388608, default 2097152
// - fault unless ratio strictly between 0.001 and 30000
// - serial encoder resolution is two to bits, bits above 30 read as 30
// - incremental encoder resolution is lines times four
// - set switchover only with pulses per rev zero
// - exactly one gear set active always
// - condition 0 waits 3 ms quiet; 1 immediate
// - select inputs pick denominator, numerator shared
// - unassigned select input reads as invalid
module egdc_core #(
  parameter QUIET_CYCLES = `EGDC_SWITCH_QUIET_MS * 1000 * `EGDC_CLK_MHZ
) (
  // clock and reset
  input wire core_clk_i,
  input wire nrst_i,
  // avalon-mm slave
  input wire [5:0] avs_address_i,
  input wire avs_read_i,
  input wire avs_write_i,
  input wire [31:0] avs_writedata_i,
  output reg [31:0] avs_readdata_o,
  output reg avs_waitrequest_o,
  // reference and feedback pulses, asynchronous
  input wire ref_pulse_i,
  input wire ref_dir_i,
  input wire fb_pulse_i,
  input wire fb_dir_i,
  // drive state and digital inputs, asynchronous
  input wire servo_enable_i,
  input wire servo_stopped_i,
  input wire fault_alarm_i,
  input wire deviation_clear_input_i,
  input wire gear_select_low_i,
  input wire gear_select_high_i,
  // status outputs
  output reg irq_o,
  output reg gear_ratio_fault_o,
  output reg [3:0] active_set_o
);

  // ****************************************
  // helpers
  // ****************************************
  // encoder resolution from type, bit count and line count
  function [30:0] enc_res;
    input inc;
    input [4:0] bits;
    input [15:0] lines;
    begin
      if (inc) begin
        enc_res = {13'h0000, lines, 2'b00};
      end else if (bits > `EGDC_MAX_ENC_BITS) begin
        enc_res = `EGDC_MAX_GEAR;
      end else begin
        enc_res = 31'h00000001 << bits;
      end
    end
  endfunction

  // limit check for numerator and denominator writes
  function gear_ok;
    input [31:0] v;
    begin
      gear_ok = (v != 32'h0) && (v <= {1'b0, `EGDC_MAX_GEAR});
    end
  endfunction

  // ****************************************
  // input synchronisers
  // ****************************************
  localparam NSYNC = 8;
  wire [NSYNC-1:0] raw_w;
  reg [NSYNC-1:0] s1_q; // first stage, read only by s2_q
  reg [NSYNC-1:0] s2_q; // usable stage
  reg [NSYNC-1:0] s3_q; // history for edge detection
  assign raw_w = {gear_select_high_i, gear_select_low_i, deviation_clear_input_i,
                  fault_alarm_i, servo_stopped_i, servo_enable_i,
                  fb_pulse_i, ref_pulse_i};

  // two flops per pin plus one history flop
  always @(posedge core_clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      s1_q <= {NSYNC{1'b0}};
      s2_q <= {NSYNC{1'b0}};
      s3_q <= {NSYNC{1'b0}};
    end else begin
      s1_q <= raw_w;
      s2_q <= s1_q;
      s3_q <= s2_q;
    end
  end

  // direction pins settle long before the pulse edge, so two flops suffice
  reg [1:0] rdir1_q;
  reg [1:0] rdir2_q;
  always @(posedge core_clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      rdir1_q <= 2'b00;
      rdir2_q <= 2'b00;
    end else begin
      rdir1_q <= {fb_dir_i, ref_dir_i};
      rdir2_q <= rdir1_q;
    end
  end

  wire ref_evt = s2_q[0] & ~s3_q[0]; // one count per rising edge
  wire fb_evt = s2_q[1] & ~s3_q[1];
  wire servo_en = s2_q[2];
  wire stopped = s2_q[3];
  wire faulted = s2_q[4];
  wire clr_lvl = s2_q[5];
  wire clr_edge = s2_q[5] & ~s3_q[5];

  // ****************************************
  // software registers
  // ****************************************
  reg [11:0] ctrl_q; // method, switch condition, form, encoder, assignments
  reg [15:0] lines_q; // incremental encoder line count
  reg [23:0] ppr_q; // pulses per revolution
  reg [30:0] num_q; // shared numerator
  reg [30:0] den_q [0:3]; // four denominators
  reg [2:0] status_q; // sticky events
  reg [2:0] mask_q; // interrupt enables
  reg signed [63:0] dev_q; // deviation in 1/A encoder counts
  reg [3:0] set_q; // one-hot active set
  reg fault_q; // live ratio fault level
  reg wait_q; // waitrequest, high when idle
  wire [1:0] method = ctrl_q[`EGDC_CTRL_METHOD_LSB +: 2];
  wire sw_cond = ctrl_q[`EGDC_CTRL_SWCOND_BIT];
  wire clr_form = ctrl_q[`EGDC_CTRL_FORM_BIT];
  wire req_w = avs_read_i | avs_write_i;
  wire take_w = req_w & ~wait_q; // transfer completes at this edge
  wire wr_w = take_w & avs_write_i;

  // ****************************************
  // gear ratio selection
  // ****************************************
  wire sel_lo = s2_q[6] & ctrl_q[`EGDC_CTRL_ASG_LOW_BIT];
  wire sel_hi = s2_q[7] & ctrl_q[`EGDC_CTRL_ASG_HIGH_BIT];
  wire [3:0] req_set = 4'b0001 << {sel_hi, sel_lo};
  reg [30:0] den_sel;
  reg [30:0] gear_b;
  reg [30:0] gear_a;
  // ratio b/a, pulses per rev takes precedence over the sets
  always @* begin
    case (set_q)
      4'b0010: den_sel = den_q[1];
      4'b0100: den_sel = den_q[2];
      4'b1000: den_sel = den_q[3];
      default: den_sel = den_q[0];
    endcase
    if (ppr_q != 24'h000000) begin
      gear_b = enc_res(ctrl_q[`EGDC_CTRL_ENCINC_BIT], ctrl_q[`EGDC_CTRL_BITS_LSB +: 5],
                       lines_q);
      gear_a = {7'h00, ppr_q};
    end else begin
      gear_b = num_q;
      gear_a = den_sel;
    end
  end
  // 0.001 < b/a < 30000 checked without division
  wire [47:0] b_lo = {17'h00000, gear_b} * `EGDC_RATIO_LO_MUL;
  wire [47:0] a_hi = {17'h00000, gear_a} * `EGDC_RATIO_HI_MUL;
  wire fault_w = (b_lo <= {17'h00000, gear_a}) | ({17'h00000, gear_b} >= a_hi);

  // ****************************************
  // switchover timer and active set
  // ****************************************
  reg [31:0] quiet_q; // cycles since last reference pulse
  wire quiet_w = (quiet_q >= QUIET_CYCLES);
  wire sw_ok = (ppr_q == 24'h000000) && (req_set != set_q) && (sw_cond || quiet_w);

  // quiet counter saturates, restarts on any reference pulse
  always @(posedge core_clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      quiet_q <= 32'h0;
    end else if (ref_evt) begin
      quiet_q <= 32'h0;
    end else if (!quiet_w) begin
      quiet_q <= quiet_q + 32'h1;
    end
  end

  // active set kept one-hot; req_set is one-hot by construction
  always @(posedge core_clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      set_q <= 4'b0001;
    end else if (sw_ok) begin
      set_q <= req_set;
    end
  end

  // ****************************************
  // deviation counter
  // ****************************************
  reg clr_w;
  // clearing condition per method
  always @* begin
    case (method)
      2'd0: clr_w = ~servo_en | stopped;
      2'd1: clr_w = ~servo_en | faulted;
      2'd2: clr_w = ~servo_en | (clr_form ? clr_lvl : clr_edge);
      default: clr_w = ~servo_en;
    endcase
    if (clr_edge) begin
      clr_w = 1'b1;
    end
  end

  wire signed [63:0] b_s = {33'h0, gear_b};
  wire signed [63:0] a_s = {33'h0, gear_a};
  wire signed [63:0] ref_d = ref_evt ? (rdir2_q[0] ? -b_s : b_s) : 64'sh0;
  wire signed [63:0] fb_d = fb_evt ? (rdir2_q[1] ? -a_s : a_s) : 64'sh0;
  // scaled reference minus scaled feedback; clear has priority
  always @(posedge core_clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      dev_q <= 64'sh0;
    end else if (clr_w) begin
      dev_q <= 64'sh0;
    end else begin
      dev_q <= dev_q + ref_d - fb_d;
    end
  end

  // ****************************************
  // register writes
  // ****************************************
  wire [2:0] evt_w = {sw_ok, fault_w & ~fault_q, clr_w & (dev_q != 64'sh0)};
  integer i;
  // configuration stores; out-of-range values are refused
  always @(posedge core_clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      ctrl_q <= `EGDC_RST_CTRL;
      lines_q <= `EGDC_RST_ENC_LINES;
      ppr_q <= `EGDC_RST_PPR;
      num_q <= `EGDC_RST_NUM;
      for (i = 0; i < 4; i = i + 1) begin
        den_q[i] <= `EGDC_RST_DEN;
      end
      mask_q <= 3'b000;
    end else if (wr_w) begin
      case (avs_address_i)
        `EGDC_OFS_CTRL: ctrl_q <= avs_writedata_i[11:0];
        `EGDC_OFS_ENC_LINES: lines_q <= avs_writedata_i[15:0];
        `EGDC_OFS_PPR: begin
          if (avs_writedata_i <= {8'h00, `EGDC_MAX_PPR}) begin
            ppr_q <= avs_writedata_i[23:0];
          end
        end
        `EGDC_OFS_NUM: begin
          if (gear_ok(avs_writedata_i)) begin
            num_q <= avs_writedata_i[30:0];
          end
        end
        `EGDC_OFS_DEN1, `EGDC_OFS_DEN2, `EGDC_OFS_DEN3, `EGDC_OFS_DEN4: begin
          if (gear_ok(avs_writedata_i)) begin
            den_q[avs_address_i[3:2]] <= avs_writedata_i[30:0];
          end
        end
        `EGDC_OFS_MASK: mask_q <= avs_writedata_i[2:0];
        default: ; // other offsets ignore writes
      endcase
    end
  end

  // sticky status, write one to clear; a new event beats the clear
  always @(posedge core_clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      status_q <= 3'b000;
    end else if (wr_w && avs_address_i == `EGDC_OFS_STATUS) begin
      status_q <= (status_q & ~avs_writedata_i[2:0]) | evt_w;
    end else begin
      status_q <= status_q | evt_w;
    end
  end

  // ****************************************
  // bus answer and outputs
  // ****************************************
  reg [31:0] rd_w;
  // read mux, unmapped offsets read zero
  always @* begin
    case (avs_address_i)
      `EGDC_OFS_CTRL: rd_w = {20'h0, ctrl_q};
      `EGDC_OFS_ENC_LINES: rd_w = {16'h0, lines_q};
      `EGDC_OFS_PPR: rd_w = {8'h0, ppr_q};
      `EGDC_OFS_NUM: rd_w = {1'b0, num_q};
      `EGDC_OFS_DEN1, `EGDC_OFS_DEN2, `EGDC_OFS_DEN3, `EGDC_OFS_DEN4:
        rd_w = {1'b0, den_q[avs_address_i[3:2]]};
      `EGDC_OFS_STATUS: rd_w = {29'h0, status_q};
      `EGDC_OFS_MASK: rd_w = {29'h0, mask_q};
      `EGDC_OFS_LIVE: rd_w = {27'h0, fault_q, set_q};
      `EGDC_OFS_DEV_LO: rd_w = dev_q[31:0];
      `EGDC_OFS_DEV_HI: rd_w = dev_q[63:32];
      default: rd_w = 32'h0;
    endcase
  end

  // one wait cycle per transfer; read data latched with the drop of waitrequest
  always @(posedge core_clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      wait_q <= 1'b1;
      avs_waitrequest_o <= 1'b1;
      avs_readdata_o <= 32'h0;
    end else begin
      wait_q <= ~(req_w & wait_q);
      avs_waitrequest_o <= ~(req_w & wait_q);
      if (req_w && wait_q && avs_read_i) begin
        avs_readdata_o <= rd_w;
      end
    end
  end

  // registered status outputs
  always @(posedge core_clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      fault_q <= 1'b0;
      gear_ratio_fault_o <= 1'b0;
      active_set_o <= 4'b0001;
      irq_o <= 1'b0;
    end else begin
      fault_q <= fault_w;
      gear_ratio_fault_o <= fault_w;
      active_set_o <= sw_ok ? req_set : set_q;
      irq_o <= |((status_q | evt_w) & mask_q);
    end
  end

endmodule // egdc_core

// *** tb/egdc_chk_assertions.sv ***
`timescale 1ns/1ps
// ****************************************
// port checker
// ****************************************
module egdc_chk (
  // clock, reset and bus
  input wire core_clk_i,
  input wire nrst_i,
  input wire [5:0] avs_address_i,
  input wire avs_read_i,
  input wire avs_write_i,
  input wire [31:0] avs_writedata_i,
  input wire [31:0] avs_readdata_o,
  input wire avs_waitrequest_o,
  // status pins
  input wire irq_o,
  input wire gear_ratio_fault_o,
  input wire [3:0] active_set_o
);
  default clocking cb @(posedge core_clk_i); endclocking
  default disable iff (!nrst_i);
  reg ppr_nz_q; // shadow: pulses per rev nonzero
  reg msk_z_q; // shadow: mask empty
  wire wr_ok = avs_write_i && !avs_waitrequest_o;
  wire rd_ok = avs_read_i && !avs_waitrequest_o;
  // shadows follow accepted writes only, refused values are skipped
  always @(posedge core_clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      ppr_nz_q <= 1'b1;
      msk_z_q <= 1'b1;
    end else if (wr_ok) begin
      if (avs_address_i == 6'h08 && avs_writedata_i <= 32'h800000) ppr_nz_q <= |avs_writedata_i;
      if (avs_address_i == 6'h24) msk_z_q <= ~|avs_writedata_i[2:0];
    end
  end
  sequence s_req; (avs_read_i || avs_write_i) && avs_waitrequest_o; endsequence
  sequence s_ans; !avs_waitrequest_o ##1 avs_waitrequest_o; endsequence
  property p_answer; s_req |=> s_ans; endproperty
  a_answer: assert property (p_answer)
    else $error("bus answer late or long");
  property p_spur; !avs_waitrequest_o |-> $past(avs_read_i || avs_write_i); endproperty
  a_spur: assert property (p_spur)
    else $error("answer without request");
  property p_unmap; rd_ok && avs_address_i > 6'h30 |-> avs_readdata_o == 32'h0; endproperty
  a_unmap: assert property (p_unmap)
    else $error("unmapped read not zero");
  property p_hold; !avs_read_i |=> $stable(avs_readdata_o); endproperty
  a_hold: assert property (p_hold)
    else $error("read data moved without read");
  property p_onehot; $onehot(active_set_o); endproperty
  a_onehot: assert property (p_onehot)
    else $error("active set not one-hot");
  property p_frozen; ppr_nz_q && $past(ppr_nz_q) |-> $stable(active_set_o); endproperty
  a_frozen: assert property (p_frozen)
    else $error("set moved with ppr nonzero");
  property p_live;
    rd_ok && avs_address_i == 6'h28 |->
      avs_readdata_o[4:0] == {$past(gear_ratio_fault_o), $past(active_set_o)};
  endproperty
  a_live: assert property (p_live)
    else $error("live word differs from pins");
  property p_irq; msk_z_q && $past(msk_z_q) |-> !irq_o; endproperty
  a_irq: assert property (p_irq)
    else $error("irq with empty mask");
endmodule // egdc_chk

// *** tb/egdc_host.sv ***
`timescale 1ns/1ps
// ****************************************
// host controller pulse source
// ****************************************
module egdc_host (
  // clock and burst request
  input wire core_clk_i,
  input wire go_i,
  input wire [7:0] count_i,
  input wire [3:0] gap_i,
  input wire dir_i,
  input wire fb_i,
  // pulse pins and state
  output reg ref_pulse_o,
  output reg ref_dir_o,
  output reg fb_pulse_o,
  output reg fb_dir_o,
  output reg busy_o
);
  integer i; // pulse index
  initial begin
    ref_pulse_o = 1'b0;
    ref_dir_o = 1'b0;
    fb_pulse_o = 1'b0;
    fb_dir_o = 1'b0;
    busy_o = 1'b0;
  end
  // one burst per request; gap of two or more keeps each phase wide enough
  always begin
    @(posedge core_clk_i);
    if (go_i) begin
      busy_o <= 1'b1;
      if (fb_i) fb_dir_o <= dir_i;
      else ref_dir_o <= dir_i;
      for (i = 0; i < count_i; i = i + 1) begin
        repeat (gap_i) @(posedge core_clk_i);
        if (fb_i) fb_pulse_o <= 1'b1;
        else ref_pulse_o <= 1'b1;
        repeat (gap_i) @(posedge core_clk_i);
        fb_pulse_o <= 1'b0;
        ref_pulse_o <= 1'b0;
      end
      busy_o <= 1'b0;
    end
  end
endmodule // egdc_host

// *** tb/tb_top.sv ***
`timescale 1ns/1ps
// ****************************************
// bench top
// ****************************************
module tb_top;
  reg core_clk_i = 1'b0;
  reg nrst_i = 1'b0;
  reg [5:0] adr = 6'h00;
  reg rd = 1'b0;
  reg wr = 1'b0;
  reg [31:0] wd = 32'h0;
  wire [31:0] rdat;
  wire wreq, rp, rdir, fp, fdir, busy, irq, flt;
  wire [3:0] aset;
  reg ena = 1'b1; // servo enable
  reg stop = 1'b0; // servo stopped
  reg alarm = 1'b0; // fault or alarm
  reg clr = 1'b0; // deviation clear input
  reg [1:0] sel = 2'b00; // gear selects, low in bit 0
  reg go = 1'b0;
  reg fb = 1'b0;
  reg [7:0] cnt = 8'h01;
  reg [3:0] gap = 4'h2;
  integer err_count = 0;
  integer n_tests = 0;
  integer seed = 32'h541b48d6;
  integer k;
  integer n;
  reg [31:0] exp_q[$]; // expected read data, oldest first
  always #5 core_clk_i = ~core_clk_i;
  // short quiet time keeps the switchover wait small
  egdc_core #(.QUIET_CYCLES(20)) dut (.core_clk_i(core_clk_i), .nrst_i(nrst_i),
    .avs_address_i(adr), .avs_read_i(rd), .avs_write_i(wr), .avs_writedata_i(wd),
    .avs_readdata_o(rdat), .avs_waitrequest_o(wreq), .ref_pulse_i(rp), .ref_dir_i(rdir),
    .fb_pulse_i(fp), .fb_dir_i(fdir), .servo_enable_i(ena), .servo_stopped_i(stop),
    .fault_alarm_i(alarm), .deviation_clear_input_i(clr), .gear_select_low_i(sel[0]),
    .gear_select_high_i(sel[1]), .irq_o(irq), .gear_ratio_fault_o(flt), .active_set_o(aset));
  egdc_host host (.core_clk_i(core_clk_i), .go_i(go), .count_i(cnt), .gap_i(gap), .dir_i(1'b0),
    .fb_i(fb), .ref_pulse_o(rp), .ref_dir_o(rdir), .fb_pulse_o(fp), .fb_dir_o(fdir),
    .busy_o(busy));
  task chk(input [31:0] e, input [31:0] s, input [63:0] nm);
    begin
      n_tests = n_tests + 1;
      if (s !== e) begin
        err_count = err_count + 1;
        $display("BAD %0s exp %h got %h", nm, e, s);
      end
    end
  endtask
  task summarize;
    begin
      $display("checks %0d mismatches %0d", n_tests, err_count);
      if (err_count == 0 && n_tests > 0) $display("No errors found");
      else $display("Errors were found");
      $finish;
    end
  endtask
  task tick(input integer c);
    repeat (c) @(posedge core_clk_i);
  endtask
  // one transfer; a read also files its expected data
  task bus(input w, input [5:0] a, input [31:0] d);
    integer t;
    begin
      t = 0;
      if (!w) exp_q.push_back(d);
      adr <= a;
      wr <= w;
      rd <= !w;
      wd <= d;
      tick(1);
      while (wreq !== 1'b0 && t < 40) begin
        tick(1);
        t = t + 1;
      end
      if (t == 40) begin
        err_count = err_count + 1;
        summarize;
      end
      rd <= 1'b0;
      wr <= 1'b0;
      tick(1);
    end
  endtask
  // bounded wait for the host to go idle
  task idle;
    begin
      n = 0;
      while (busy === 1'b1 && n < 999) begin
        tick(1);
        n = n + 1;
      end
      if (n == 999) begin
        err_count = err_count + 1;
        summarize;
      end
    end
  endtask
  task launch(input [7:0] c, input f);
    begin
      cnt <= c;
      fb <= f;
      go <= 1'b1;
      gap <= 4'd2 + $unsigned($random(seed)) % 4;
      tick(1);
      go <= 1'b0;
      tick(1);
    end
  endtask
  // read answers are compared against the oldest note
  always @(posedge core_clk_i) begin
    if (rd && wreq === 1'b0) chk(exp_q.pop_front(), rdat, "rdata");
  end
  initial begin
    repeat (100000) @(posedge core_clk_i);
    err_count = err_count + 1;
    summarize;
  end
  initial begin
    tick(16);
    nrst_i <= 1'b1;
    tick(1);
    bus(0, 6'h08, 32'h200000);
    bus(0, 6'h0c, 32'h800000);
    bus(0, 6'h34, 32'h0);
    bus(1, 6'h08, 32'h800001);
    bus(0, 6'h08, 32'h200000);
    bus(1, 6'h08, 32'h800000);
    bus(0, 6'h08, 32'h800000);
    bus(1, 6'h00, 32'h140);
    bus(0, 6'h28, 32'h11);
    chk(1, flt, "fault");
    bus(1, 6'h00, 32'h220);
    bus(1, 6'h08, 32'h4);
    bus(0, 6'h28, 32'h11);
    bus(1, 6'h08, 32'h5);
    bus(0, 6'h28, 32'h01);
    chk(0, flt, "fault");
    bus(1, 6'h00, 32'h230);
    bus(1, 6'h04, 32'd37500);
    bus(0, 6'h28, 32'h11);
    bus(1, 6'h04, 32'd37499);
    bus(0, 6'h28, 32'h01);
    bus(1, 6'h00, 32'h220);
    bus(1, 6'h24, 32'h1);
    k = 1 + $unsigned($random(seed)) % 8;
    launch(k, 0);
    idle;
    launch(1, 1);
    idle;
    bus(0, 6'h2c, k * 131072 - 5);
    bus(0, 6'h30, 32'h0);
    for (k = 0; k < 6; k = k + 1) begin
      bus(1, 6'h20, 32'h7);
      tick(2);
      chk(0, irq, "irq");
      bus(1, 6'h00, k == 1 ? 32'h221 : k == 2 ? 32'h22a : k == 4 ? 32'h222 :
          k == 5 ? 32'h223 : 32'h220);
      launch(2, 0);
      idle;
      stop <= (k == 0);
      alarm <= (k == 1);
      clr <= (k >= 2 && k < 5);
      ena <= (k != 5);
      tick(8);
      chk(1, irq, "irq");
      launch(2, 0);
      idle;
      stop <= 1'b0;
      alarm <= 1'b0;
      clr <= 1'b0;
      ena <= 1'b1;
      tick(4);
      bus(0, 6'h2c, (k == 3 || k == 4) ? 32'h40000 : 32'h0);
    end
    bus(1, 6'h08, 32'h0);
    bus(1, 6'h00, 32'he24);
    for (k = 0; k < 4; k = k + 1) begin
      sel <= k[1:0];
      tick(8);
      bus(0, 6'h28, 32'h1 << k);
    end
    // cleared earlier plus set switched, then write one to clear both
    bus(0, 6'h20, 32'h5);
    bus(1, 6'h20, 32'h5);
    bus(0, 6'h20, 32'h0);
    bus(1, 6'h00, 32'h224);
    tick(8);
    bus(0, 6'h28, 32'h1);
    sel <= 2'b00;
    bus(1, 6'h00, 32'he20);
    tick(40);
    launch(8, 0);
    tick(12);
    sel <= 2'b01;
    tick(8);
    bus(0, 6'h28, 32'h1);
    idle;
    tick(30);
    bus(0, 6'h28, 32'h2);
    bus(1, 6'h08, 32'h5);
    sel <= 2'b11;
    tick(40);
    bus(0, 6'h28, 32'h2);
    chk(32'h2, aset, "aset");
    summarize;
  end
endmodule // tb_top
bind egdc_core egdc_chk u_chk (.core_clk_i(core_clk_i), .nrst_i(nrst_i),
  .avs_address_i(avs_address_i), .avs_read_i(avs_read_i), .avs_write_i(avs_write_i),
  .avs_writedata_i(avs_writedata_i), .avs_readdata_o(avs_readdata_o),
  .avs_waitrequest_o(avs_waitrequest_o), .irq_o(irq_o),
  .gear_ratio_fault_o(gear_ratio_fault_o), .active_set_o(active_set_o));
